/* rtl/pdm_pkg.sv */
package pdm_pkg;
    // Word width shared by every area except the temporary branch bits
    localparam int WORD_W = 16;
    localparam int BIT_IDX_W = 4;
    // Holding area: 100 words
    localparam int HOLD_WORDS = 100;
    localparam int HOLD_AW = 7;
    // Words that the ring routing table and monitor timer may take
    localparam logic [6:0] HOLD_RING_LAST = 7'h2a;
    // Timer/counter area: 512 entries
    localparam int TC_ENTRIES = 512;
    localparam int TC_AW = 9;
    // Link area: 64 words
    localparam int LINK_WORDS = 64;
    localparam int LINK_AW = 6;
    // Data memory: special I/O slices
    localparam logic [10:0] DM_SIO_BASE = 11'h3e8;
    localparam logic [10:0] DM_SIO_LAST = 11'h7cf;
    localparam logic [10:0] DM_SLICE_WORDS = 11'h064;
    localparam int SIO_UNITS = 10;
    // Temporary branch bits
    localparam int TBR_BITS = 8;
    // Program memory sizes in words
    localparam logic [13:0] PROG_4K = 14'h1000;
    localparam logic [13:0] PROG_8K = 14'h2000;
    // Area selector codes
    typedef enum logic [2:0] {
        PDM_AREA_HOLD = 3'h0,
        PDM_AREA_TC = 3'h1,
        PDM_AREA_LINK = 3'h3,
        PDM_AREA_DM = 3'h2,
        PDM_AREA_TBR = 3'h6
    } pdm_area_t;
    // Clearing sequencer states, Gray from IDLE through CLR to DONE
    typedef enum logic [1:0] {
        PDM_ST_IDLE = 2'h0,
        PDM_ST_CLR = 2'h1,
        PDM_ST_DONE = 2'h3
    } pdm_state_t;
endpackage

/* rtl/pdm_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// Single-port word memory with registered read data
module pdm_mem #(
    parameter int DEPTH = 64,
    parameter int AW = 6,
    parameter int DW = 16
) (
    input wire logic clk_sys,
    input wire logic ce,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    // Storage array, no reset so contents survive controller resets
    logic [DW-1:0] mem [DEPTH];

    initial begin
        if (DEPTH > (1 << AW)) begin
            $error("pdm_mem depth exceeds address range");
        end
    end

    // Write and registered read
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule
`default_nettype wire

/* rtl/pdm_core.sv */
`timescale 1ns/1ps
`default_nettype none
module pdm_core #(
    parameter int HOLD_N = pdm_pkg::HOLD_WORDS,
    parameter int TC_N = pdm_pkg::TC_ENTRIES,
    parameter int LINK_N = pdm_pkg::LINK_WORDS
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Operand access from the scan engine
    input wire logic acc_req,
    input wire logic acc_we,
    input wire logic acc_bit,
    input wire logic acc_ldout,
    input wire logic acc_periph,
    input wire logic [2:0] acc_area,
    input wire logic [10:0] acc_word,
    input wire logic [3:0] acc_bit_idx,
    input wire logic [15:0] acc_wdata,
    input wire logic acc_sv,
    // Timer/counter definition check
    input wire logic def_valid,
    input wire logic [8:0] def_num,
    input wire logic def_is_timer,
    input wire logic def_clear,
    // Lifecycle events
    input wire logic power_up,
    input wire logic op_start,
    input wire logic prog_mode_entry,
    input wire logic il_reset,
    // Link configuration
    input wire logic [63:0] link_own_mask,
    input wire logic p2p_link_active,
    input wire logic ring_link_req,
    input wire logic ring_option,
    input wire logic mem_unit_8k,
    // Link transfer in from other controllers
    input wire logic link_in_valid,
    input wire logic [5:0] link_in_word,
    input wire logic [15:0] link_in_data,
    // Outputs
    output logic [15:0] acc_rdata,
    output logic acc_rbit,
    output logic acc_ack,
    output logic acc_err,
    output logic def_err,
    output logic link_out_valid,
    output logic [5:0] link_out_word,
    output logic [15:0] link_out_data,
    output logic ring_grant,
    output logic [13:0] prog_capacity
);
    initial begin
        if (HOLD_N != pdm_pkg::HOLD_WORDS || LINK_N != pdm_pkg::LINK_WORDS
            || TC_N != pdm_pkg::TC_ENTRIES) begin
            $error("pdm_core sizes must match the area map");
        end
    end

    // Word storage for holding area, not reset (retained)
    logic [15:0] hold_mem [pdm_pkg::HOLD_WORDS];
    // Link area storage, cleared by power-up, interlock reset and program mode entry
    logic [15:0] link_mem [pdm_pkg::LINK_WORDS];
    // Timer/counter flags, kinds and defined marks
    logic [pdm_pkg::TC_ENTRIES-1:0] tc_flag_r;
    logic [pdm_pkg::TC_ENTRIES-1:0] tc_timer_r;
    logic [pdm_pkg::TC_ENTRIES-1:0] tc_def_r;
    // Temporary branch bits
    logic [pdm_pkg::TBR_BITS-1:0] tbr_r;
    // Clear sequencer for present values
    pdm_pkg::pdm_state_t clr_st_r;
    logic [8:0] clr_idx_r;
    logic clr_link_r;

    // Decode helpers
    function automatic logic [15:0] set_bit(input logic [15:0] w,
        input logic [3:0] i, input logic v);
        logic [15:0] r;
        r = w;
        r[i] = v;
        return r;
    endfunction

    function automatic logic dm_is_sio(input logic [10:0] a);
        return a >= pdm_pkg::DM_SIO_BASE && a <= pdm_pkg::DM_SIO_LAST;
    endfunction

    // Decoded access classes
    pdm_pkg::pdm_area_t area;
    logic a_hold, a_tc, a_link, a_dm, a_tbr, a_ok, a_wr;
    logic link_busy;
    assign area = pdm_pkg::pdm_area_t'(acc_area);
    assign a_hold = area == pdm_pkg::PDM_AREA_HOLD
        && acc_word < 11'(pdm_pkg::HOLD_WORDS);
    assign a_tc = area == pdm_pkg::PDM_AREA_TC
        && acc_word < 11'(pdm_pkg::TC_ENTRIES);
    assign a_link = area == pdm_pkg::PDM_AREA_LINK
        && acc_word < 11'(pdm_pkg::LINK_WORDS);
    // Data memory is word only; special I/O slice writes need a peripheral, reads do not
    assign a_dm = area == pdm_pkg::PDM_AREA_DM && !acc_bit
        && acc_word <= pdm_pkg::DM_SIO_LAST;
    // Branch bits only for load/output, bit index 0..7
    assign a_tbr = area == pdm_pkg::PDM_AREA_TBR && acc_ldout
        && acc_word == 11'h000
        && acc_bit_idx < 4'(pdm_pkg::TBR_BITS);
    assign link_busy = clr_link_r;
    assign a_ok = a_hold || a_tc || a_link || a_dm || a_tbr;
    // Write allowed: link only own words; special I/O only peripheral
    assign a_wr = acc_we && a_ok
        && !(a_link && !link_own_mask[acc_word[5:0]])
        && !(a_dm && dm_is_sio(acc_word) && !acc_periph)
        && !(a_link && link_busy);

    // Data memory in its own module
    logic [15:0] dm_rdata;
    pdm_mem #(.DEPTH(2000), .AW(11), .DW(16)) u_dm (
        .clk_sys(clk_sys),
        .ce(ce),
        .we(a_wr && a_dm && acc_req),
        .addr(acc_word),
        .wdata(acc_wdata),
        .rdata(dm_rdata)
    );

    // Timer/counter set and present values share one memory
    logic [15:0] tc_rdata;
    logic tc_we;
    logic [9:0] tc_addr;
    logic [15:0] tc_wd;
    // Clearing sweep takes the port; scan word writes in that time are dropped and reads return zero
    always_comb begin
        tc_we = 1'b0;
        tc_addr = {acc_sv, acc_word[8:0]};
        tc_wd = acc_wdata;
        if (clr_st_r == pdm_pkg::PDM_ST_CLR) begin
            tc_addr = {1'b0, clr_idx_r};
            tc_wd = 16'h0000;
            tc_we = tc_timer_r[clr_idx_r];
        end else if (acc_req && a_wr && a_tc && !acc_bit) begin
            tc_we = 1'b1;
        end
    end
    pdm_mem #(.DEPTH(1024), .AW(10), .DW(16)) u_tc (
        .clk_sys(clk_sys),
        .ce(ce),
        .we(tc_we),
        .addr(tc_addr),
        .wdata(tc_wd),
        .rdata(tc_rdata)
    );

    // Clear sequencer: timer present values and link area
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clr_st_r <= pdm_pkg::PDM_ST_CLR;
            clr_idx_r <= 9'h000;
            clr_link_r <= 1'b1;
        end else if (ce) begin
            case (clr_st_r)
                pdm_pkg::PDM_ST_IDLE: begin
                    if (op_start || il_reset || power_up
                        || prog_mode_entry) begin
                        clr_st_r <= pdm_pkg::PDM_ST_CLR;
                        clr_idx_r <= 9'h000;
                        clr_link_r <= il_reset || power_up || prog_mode_entry;
                    end
                end
                pdm_pkg::PDM_ST_CLR: begin
                    clr_idx_r <= clr_idx_r + 9'h001;
                    if (clr_idx_r == 9'(pdm_pkg::TC_ENTRIES - 1)) begin
                        clr_st_r <= pdm_pkg::PDM_ST_DONE;
                    end
                end
                pdm_pkg::PDM_ST_DONE: begin
                    clr_link_r <= 1'b0;
                    clr_st_r <= pdm_pkg::PDM_ST_IDLE;
                end
                default: clr_st_r <= pdm_pkg::PDM_ST_IDLE;
            endcase
        end
    end

    // Link area: cleared by sweep, written locally or by transfers
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            if (clr_st_r == pdm_pkg::PDM_ST_CLR && clr_link_r
                && clr_idx_r < 9'(pdm_pkg::LINK_WORDS)) begin
                link_mem[clr_idx_r[5:0]] <= 16'h0000;
            end else if (acc_req && a_wr && a_link) begin
                link_mem[acc_word[5:0]] <= acc_bit
                    ? set_bit(link_mem[acc_word[5:0]], acc_bit_idx,
                        acc_wdata[0])
                    : acc_wdata;
            end else if (link_in_valid && !link_own_mask[link_in_word]) begin
                link_mem[link_in_word] <= link_in_data;
            end
        end
    end

    // Holding area writes; never cleared by any event
    always_ff @(posedge clk_sys) begin
        if (ce && acc_req && a_wr && a_hold) begin
            hold_mem[acc_word[6:0]] <= acc_bit
                ? set_bit(hold_mem[acc_word[6:0]], acc_bit_idx,
                    acc_wdata[0])
                : acc_wdata;
        end
    end

    // Completion flags and branch bits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tc_flag_r <= '0;
            tbr_r <= '0;
        end else if (ce && acc_req && a_wr) begin
            if (a_tc && acc_bit) begin
                tc_flag_r[acc_word[8:0]] <= acc_wdata[0];
            end
            if (a_tbr) begin
                tbr_r[acc_bit_idx[2:0]] <= acc_wdata[0];
            end
        end
    end

    // Definition check: second definition of a number is an error
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tc_def_r <= '0;
            tc_timer_r <= '0;
            def_err <= 1'b0;
        end else if (ce) begin
            if (def_clear) begin
                tc_def_r <= '0;
                def_err <= 1'b0;
            end else if (def_valid) begin
                if (tc_def_r[def_num]) begin
                    def_err <= 1'b1;
                end
                tc_def_r[def_num] <= 1'b1;
                tc_timer_r[def_num] <= def_is_timer;
            end
        end
    end

    // Access answer, one cycle after the request
    logic rd_dm_r, rd_tc_r;
    logic [15:0] word_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_ack <= 1'b0;
            acc_err <= 1'b0;
            word_r <= 16'h0000;
            acc_rbit <= 1'b0;
            rd_dm_r <= 1'b0;
            rd_tc_r <= 1'b0;
        end else if (ce) begin
            acc_ack <= acc_req;
            acc_err <= acc_req && (!a_ok || (acc_we && !a_wr));
            rd_dm_r <= acc_req && a_dm;
            rd_tc_r <= acc_req && a_tc && !acc_bit
                && clr_st_r != pdm_pkg::PDM_ST_CLR;
            acc_rbit <= 1'b0;
            word_r <= 16'h0000;
            if (acc_req && a_hold) begin
                word_r <= hold_mem[acc_word[6:0]];
                acc_rbit <= hold_mem[acc_word[6:0]][acc_bit_idx];
            end else if (acc_req && a_link) begin
                word_r <= link_mem[acc_word[5:0]];
                acc_rbit <= link_mem[acc_word[5:0]][acc_bit_idx];
            end else if (acc_req && a_tc && acc_bit) begin
                acc_rbit <= tc_flag_r[acc_word[8:0]];
            end else if (acc_req && a_tbr) begin
                acc_rbit <= tbr_r[acc_bit_idx[2:0]];
            end
        end
    end

    // Memory ports already register their read data
    assign acc_rdata = rd_dm_r ? dm_rdata : (rd_tc_r ? tc_rdata : word_r);

    // Outbound link words, ring grant, program capacity
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            link_out_valid <= 1'b0;
            link_out_word <= 6'h00;
            link_out_data <= 16'h0000;
            ring_grant <= 1'b0;
            prog_capacity <= pdm_pkg::PROG_4K;
        end else if (ce) begin
            link_out_valid <= acc_req && a_wr && a_link;
            link_out_word <= acc_word[5:0];
            link_out_data <= acc_bit ? set_bit(link_mem[acc_word[5:0]],
                acc_bit_idx, acc_wdata[0]) : acc_wdata;
            ring_grant <= ring_link_req && ring_option
                && !p2p_link_active;
            prog_capacity <= mem_unit_8k ? pdm_pkg::PROG_8K
                : pdm_pkg::PROG_4K;
        end
    end

    // Ring reservation limit is fixed; only range usage is checked
    logic ring_hold_ok;
    assign ring_hold_ok = HOLD_N
        > int'(pdm_pkg::HOLD_RING_LAST);

    slice_map_a: assert property (@(posedge clk_sys) disable iff (rst)
        acc_req && ce && acc_we && !acc_periph && area == pdm_pkg::PDM_AREA_DM
        && dm_is_sio(acc_word) |=> acc_err)
        else $error("special I/O slice written by program");
    dm_word_a: assert property (@(posedge clk_sys) disable iff (rst)
        acc_req && ce && area == pdm_pkg::PDM_AREA_DM && acc_bit
        |=> acc_err)
        else $error("data memory bit access not refused");
    hold_range_a: assert property (@(posedge clk_sys) disable iff (rst)
        acc_req && ce && area == pdm_pkg::PDM_AREA_HOLD
        && acc_word > 11'h063 |=> acc_err)
        else $error("holding word past 99 accepted");
    ring_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        ring_hold_ok)
        else $error("ring reservation outside holding area");
    tc_range_a: assert property (@(posedge clk_sys) disable iff (rst)
        acc_req && ce && area == pdm_pkg::PDM_AREA_TC
        && acc_word > 11'h1ff |=> acc_err)
        else $error("timer number past 511 accepted");
    def_twice_a: assert property (@(posedge clk_sys) disable iff (rst)
        ce && def_valid && !def_clear
        && tc_def_r[def_num] |=> def_err)
        else $error("double definition not reported");
    link_own_a: assert property (@(posedge clk_sys) disable iff (rst)
        acc_req && ce && acc_we && a_link && !link_own_mask[acc_word[5:0]]
        |=> acc_err && !link_out_valid)
        else $error("foreign link word written");
    ring_p2p_a: assert property (@(posedge clk_sys) disable iff (rst)
        ce && p2p_link_active |=> !ring_grant)
        else $error("ring granted while link busy");
    link_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
        ce && clr_st_r == pdm_pkg::PDM_ST_IDLE && prog_mode_entry
        |=> clr_link_r [*3])
        else $error("link clear not started");
    cap_a: assert property (@(posedge clk_sys) disable iff (rst)
        ce && mem_unit_8k |=> prog_capacity == 14'h2000)
        else $error("capacity not 8K");
    tbr_only_a: assert property (@(posedge clk_sys) disable iff (rst)
        acc_req && ce && area == pdm_pkg::PDM_AREA_TBR && !acc_ldout
        |=> acc_err)
        else $error("branch bit used by other instruction");
    c_link_c: cover property (@(posedge clk_sys) link_out_valid);
    c_def_c: cover property (@(posedge clk_sys) def_err);
    c_ring_c: cover property (@(posedge clk_sys) ring_grant);
    c_clr_c: cover property (@(posedge clk_sys)
        clr_st_r == pdm_pkg::PDM_ST_DONE);
endmodule
`default_nettype wire

/* tb/pdm_link_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// Another controller on the link, sending its write words to us
module pdm_link_peer (
    input wire logic clk_sys,
    output logic link_in_valid,
    output logic [5:0] link_in_word,
    output logic [15:0] link_in_data
);
    // Quiet lines at time zero
    initial begin
        link_in_valid = 1'b0;
        link_in_word = 6'h00;
        link_in_data = 16'h0000;
    end
    // One word, held for exactly one clock
    task automatic send(input logic [5:0] w, input logic [15:0] d);
        @(posedge clk_sys);
        #1;
        link_in_valid = 1'b1;
        link_in_word = w;
        link_in_data = d;
        @(posedge clk_sys);
        #1;
        link_in_valid = 1'b0;
        // Released lines show the inverse
        link_in_word = ~w;
        link_in_data = ~d;
    endtask
endmodule
`default_nettype wire

/* tb/plc_data_memory_areas_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the controller data memory core
module plc_data_memory_areas_tb_top;
    // Access flag bits: write, bit, load/output, programming device
    localparam logic [3:0] FW = 4'h8;
    localparam logic [3:0] FB = 4'h4;
    localparam logic [3:0] FL = 4'h2;
    localparam logic [3:0] FP = 4'h1;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic acc_req = 0, acc_we = 0, acc_bit = 0, acc_ldout = 0;
    logic acc_periph = 0, acc_sv = 0;
    logic [2:0] acc_area = 3'h0;
    logic [10:0] acc_word = 11'h000;
    logic [3:0] acc_bit_idx = 4'h0;
    logic [15:0] acc_wdata = 16'h0000;
    logic def_valid = 0, def_is_timer = 0, def_clear = 0;
    logic [8:0] def_num = 9'h000;
    logic power_up = 0, op_start = 0, prog_mode_entry = 0, il_reset = 0;
    logic [63:0] link_own_mask = 64'h8000_0000_0000_0008;
    logic p2p_link_active = 0, ring_link_req = 0, ring_option = 0;
    logic mem_unit_8k = 0;
    logic link_in_valid;
    logic [5:0] link_in_word;
    logic [15:0] link_in_data;
    logic [15:0] acc_rdata, link_out_data;
    logic acc_rbit, acc_ack, acc_err, def_err, link_out_valid, ring_grant;
    logic [5:0] link_out_word;
    logic [13:0] prog_capacity;
    int fails = 0;
    int samples_checked = 0;
    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;
    // Core under test; ce held high
    pdm_core dut (
        .clk_sys(clk_sys), .rst(rst), .ce(1'b1),
        .acc_req(acc_req), .acc_we(acc_we), .acc_bit(acc_bit),
        .acc_ldout(acc_ldout), .acc_periph(acc_periph),
        .acc_area(acc_area), .acc_word(acc_word),
        .acc_bit_idx(acc_bit_idx), .acc_wdata(acc_wdata), .acc_sv(acc_sv),
        .def_valid(def_valid), .def_num(def_num),
        .def_is_timer(def_is_timer), .def_clear(def_clear),
        .power_up(power_up), .op_start(op_start),
        .prog_mode_entry(prog_mode_entry), .il_reset(il_reset),
        .link_own_mask(link_own_mask), .p2p_link_active(p2p_link_active),
        .ring_link_req(ring_link_req), .ring_option(ring_option),
        .mem_unit_8k(mem_unit_8k), .link_in_valid(link_in_valid),
        .link_in_word(link_in_word), .link_in_data(link_in_data),
        .acc_rdata(acc_rdata), .acc_rbit(acc_rbit), .acc_ack(acc_ack),
        .acc_err(acc_err), .def_err(def_err),
        .link_out_valid(link_out_valid), .link_out_word(link_out_word),
        .link_out_data(link_out_data), .ring_grant(ring_grant),
        .prog_capacity(prog_capacity)
    );
    // Far-side controller model
    pdm_link_peer peer (
        .clk_sys(clk_sys), .link_in_valid(link_in_valid),
        .link_in_word(link_in_word), .link_in_data(link_in_data)
    );
    // Counts every compare, reports a difference at once
    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Single place where the run ends
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One operand access; answer stands in the cycle after the request
    task automatic acc(input logic [2:0] ar, input logic [10:0] w,
                       input logic [3:0] bi, input logic [3:0] fl,
                       input logic [15:0] wd);
        @(posedge clk_sys);
        #1;
        acc_req = 1'b1;
        acc_area = ar;
        acc_word = w;
        acc_bit_idx = bi;
        {acc_we, acc_bit, acc_ldout, acc_periph} = fl;
        acc_wdata = wd;
        @(posedge clk_sys);
        #1;
        acc_req = 1'b0;
    endtask
    // Status outputs by number for bounded waits
    function automatic logic [15:0] stat(input int s);
        case (s)
            0: stat = {15'h0000, ring_grant};
            1: stat = {2'h0, prog_capacity};
            default: stat = {15'h0000, def_err};
        endcase
    endfunction
    // Wait at most eight cycles; a spent bound ends the run
    task automatic wait_val(input string nm, input int s,
                            input logic [15:0] exp);
        int n;
        for (n = 0; n < 8 && stat(s) !== exp; n++) begin
            @(posedge clk_sys);
            #1;
        end
        check(nm, stat(s), exp);
        if (stat(s) !== exp) begin
            report_and_stop();
        end
    endtask
    // Lifecycle pulse: 0 power, 1 start, 2 program mode, 3 interlock
    task automatic pulse_event(input int k);
        @(posedge clk_sys);
        #1;
        case (k)
            0: power_up = 1'b1;
            1: op_start = 1'b1;
            2: prog_mode_entry = 1'b1;
            default: il_reset = 1'b1;
        endcase
        @(posedge clk_sys);
        #1;
        {power_up, op_start, prog_mode_entry, il_reset} = 4'h0;
    endtask
    // One timer/counter definition, or a check restart
    task automatic define(input logic [8:0] num, input logic tim,
                          input logic clr);
        @(posedge clk_sys);
        #1;
        {def_valid, def_clear} = {~clr, clr};
        def_num = num;
        def_is_timer = tim;
        @(posedge clk_sys);
        #1;
        {def_valid, def_clear} = 2'h0;
    endtask
    // Holding words and bits, top boundary and one past it
    task automatic t_hold();
        acc(pdm_pkg::PDM_AREA_HOLD, 11'h063, 4'h0, FW, 16'ha5c3);
        check("hold write ack", acc_ack, 1'b1);
        acc(pdm_pkg::PDM_AREA_HOLD, 11'h063, 4'hf, FW | FB, 16'h0000);
        acc(pdm_pkg::PDM_AREA_HOLD, 11'h063, 4'h0, 4'h0, 16'h0000);
        check("hold word", acc_rdata, 16'h25c3);
        acc(pdm_pkg::PDM_AREA_HOLD, 11'h063, 4'h0, FB, 16'h0000);
        check("hold bit", acc_rbit, 1'b1);
        acc(pdm_pkg::PDM_AREA_HOLD, 11'h064, 4'h0, 4'h0, 16'h0000);
        check("hold range", acc_err, 1'b1);
        $display("holding test done");
    endtask
    // Data memory: no bit access, unit slice writes need the programming device
    task automatic t_dm();
        int u;
        acc(pdm_pkg::PDM_AREA_DM, 11'h3e7, 4'h0, FW, 16'h1234);
        check("dm user ack", acc_ack, 1'b1);
        acc(pdm_pkg::PDM_AREA_DM, 11'h3e7, 4'h0, 4'h0, 16'h0);
        check("dm word", acc_rdata, 16'h1234);
        acc(pdm_pkg::PDM_AREA_DM, 11'h005, 4'h3, FB, 16'h0000);
        check("dm bit", acc_err, 1'b1);
        acc(pdm_pkg::PDM_AREA_DM, 11'h3e8, 4'h0, FW, 16'h0001);
        check("dm slice no dev", acc_err, 1'b1);
        for (u = 0; u < 10; u++) begin
            acc(pdm_pkg::PDM_AREA_DM, 11'(1000 + u * 100 + 99), 4'h0,
                FW | FP, 16'(u));
            check("dm slice ack", acc_ack, 1'b1);
        end
        acc(pdm_pkg::PDM_AREA_DM, 11'h7d0, 4'h0, FW | FP, 16'h0001);
        check("dm past end", acc_err, 1'b1);
        $display("data memory test done");
    endtask
    // Timer/counter numbers: last entry, one past it, both operand kinds
    task automatic t_tc();
        acc(pdm_pkg::PDM_AREA_TC, 11'h1ff, 4'h0, FB, 16'h0000);
        check("tc bit ack", acc_ack, 1'b1);
        acc(pdm_pkg::PDM_AREA_TC, 11'h1ff, 4'h0, 4'h0, 16'h0000);
        check("tc word ack", acc_ack, 1'b1);
        acc_sv = 1'b1;
        acc(pdm_pkg::PDM_AREA_TC, 11'h000, 4'h0, FW | FP, 16'h0100);
        check("tc set ack", acc_ack, 1'b1);
        acc_sv = 1'b0;
        acc(pdm_pkg::PDM_AREA_TC, 11'h200, 4'h0, 4'h0, 16'h0000);
        check("tc range", acc_err, 1'b1);
        $display("timer counter test done");
    endtask
    // Definition check: any order is fine, any repeat is an error
    task automatic t_def();
        define(9'h1ff, 1'b1, 1'b0);
        define(9'h000, 1'b0, 1'b0);
        define(9'h005, 1'b1, 1'b0);
        repeat (3) @(posedge clk_sys);
        #1;
        check("def clean", def_err, 1'b0);
        define(9'h005, 1'b0, 1'b0);
        wait_val("def other kind", 2, 16'h0001);
        define(9'h000, 1'b0, 1'b1);
        wait_val("def restart", 2, 16'h0000);
        define(9'h007, 1'b1, 1'b0);
        define(9'h007, 1'b1, 1'b0);
        wait_val("def same kind", 2, 16'h0001);
        define(9'h000, 1'b0, 1'b1);
        $display("definition test done");
    endtask
    // Own words go out; foreign words come in, read-only
    task automatic t_link();
        acc(pdm_pkg::PDM_AREA_LINK, 11'h003, 4'h0, FW, 16'h5a5a);
        check("link out valid", link_out_valid, 1'b1);
        check("link out word", link_out_word, 6'h03);
        check("link out data", link_out_data, 16'h5a5a);
        acc(pdm_pkg::PDM_AREA_LINK, 11'h03f, 4'hf, FW | FB, 16'h0001);
        acc(pdm_pkg::PDM_AREA_LINK, 11'h03f, 4'h0, 4'h0, 16'h0000);
        check("link top bit", acc_rdata, 16'h8000);
        acc(pdm_pkg::PDM_AREA_LINK, 11'h00a, 4'h0, FW, 16'h0001);
        check("link foreign wr", acc_err, 1'b1);
        acc(pdm_pkg::PDM_AREA_LINK, 11'h040, 4'h0, 4'h0, 16'h0000);
        check("link range", acc_err, 1'b1);
        peer.send(6'h0a, 16'h1357);
        acc(pdm_pkg::PDM_AREA_LINK, 11'h00a, 4'h0, 4'h0, 16'h0000);
        check("link in word", acc_rdata, 16'h1357);
        peer.send(6'h03, 16'hffff);
        acc(pdm_pkg::PDM_AREA_LINK, 11'h003, 4'h0, 4'h0, 16'h0000);
        check("link own kept", acc_rdata, 16'h5a5a);
        $display("link test done");
    endtask
    // Each lifecycle event: holding kept, link cleared where it must be
    task automatic t_events();
        int k;
        acc(pdm_pkg::PDM_AREA_HOLD, 11'h02a, 4'h0, FW, 16'h0f0f);
        for (k = 0; k < 4; k++) begin
            acc(pdm_pkg::PDM_AREA_LINK, 11'h003, 4'h0, FW, 16'(8'hc0 + k));
            pulse_event(k);
            if (k == 0) begin
                acc(pdm_pkg::PDM_AREA_LINK, 11'h003, 4'h0, FW, 16'h0001);
                check("link in sweep", acc_err, 1'b1);
            end
            repeat (520) @(posedge clk_sys);
            acc(pdm_pkg::PDM_AREA_HOLD, 11'h02a, 4'h0, 4'h0, 16'h0000);
            check("hold kept", acc_rdata, 16'h0f0f);
            acc(pdm_pkg::PDM_AREA_LINK, 11'h003, 4'h0, 4'h0, 16'h0);
            check("link", acc_rdata, k == 1 ? 16'hc1 : 16'h0);
        end
        $display("event test done");
    endtask
    // Branch bits only through load/output, index 0 to 7
    task automatic t_tbr();
        acc(pdm_pkg::PDM_AREA_TBR, 11'h000, 4'h7, FW | FB | FL, 16'h0001);
        acc(pdm_pkg::PDM_AREA_TBR, 11'h000, 4'h7, FB | FL, 16'h0000);
        check("branch bit", acc_rbit, 1'b1);
        acc(pdm_pkg::PDM_AREA_TBR, 11'h000, 4'h7, FB, 16'h0000);
        check("branch no ldout", acc_err, 1'b1);
        acc(pdm_pkg::PDM_AREA_TBR, 11'h000, 4'h8, FB | FL, 16'h0000);
        check("branch range", acc_err, 1'b1);
        $display("branch test done");
    endtask
    // Ring use of the link area and program memory size
    task automatic t_cfg();
        {ring_option, ring_link_req} = 2'h3;
        wait_val("ring free", 0, 16'h0001);
        p2p_link_active = 1'b1;
        wait_val("ring blocked", 0, 16'h0000);
        mem_unit_8k = 1'b1;
        wait_val("prog 8k", 1, {2'h0, pdm_pkg::PROG_8K});
        mem_unit_8k = 1'b0;
        wait_val("prog 4k", 1, {2'h0, pdm_pkg::PROG_4K});
        $display("config test done");
    endtask
    // Main sequence: reset, power-on sweep, scenarios
    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        check("reset ack", acc_ack, 1'b0);
        check("reset cap", prog_capacity, 14'h1000);
        rst = 1'b0;
        repeat (520) @(posedge clk_sys);
        t_hold();
        t_dm();
        t_tc();
        t_def();
        t_link();
        t_tbr();
        t_cfg();
        t_events();
        report_and_stop();
    end
endmodule
`default_nettype wire
